// ---- verilog/aps_pkg.sv ----
// shared constants for the audio peak led sync path
package aps_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int SMP_W = 12;
    localparam int DAT_W = 16;
    localparam int LED_W = 8;
    localparam int FIFO_DEPTH = 4;
    // high-pass coefficients, Q16, for a 32 kHz sample rate
    localparam logic [15:0] HP_ALPHA_80HZ = 16'h0405;
    localparam logic [15:0] HP_ALPHA_510HZ = 16'h19a2;
    // manual gain table in Q8: 0, -6, -12, -18, -24, -31, -37, -46 dB
    localparam logic [8:0] GAIN_Q8 [8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h007, 9'h004, 9'h001};
    // auto gain limits: peak counts for 10,20,40,85,170,400,800 mV peak-to-peak
    localparam logic [15:0] AGC_LIM [7] = '{16'h000d, 16'h001a, 16'h0033, 16'h006d, 16'h00da, 16'h0200, 16'h0400};
    // refresh rates in tenths of a hertz
    localparam int unsigned RATE_FAST_DHZ = 300;
    localparam int unsigned RATE_15_DHZ = 150;
    localparam int unsigned RATE_7P6_DHZ = 76;
    localparam int unsigned RATE_3P8_DHZ = 38;
    localparam int unsigned REFRESH_FAST_CYC = CLK_HZ / RATE_FAST_DHZ * 10;
    localparam int unsigned REFRESH_15_CYC = CLK_HZ / RATE_15_DHZ * 10;
    localparam int unsigned REFRESH_7P6_CYC = CLK_HZ / RATE_7P6_DHZ * 10;
    localparam int unsigned REFRESH_3P8_CYC = CLK_HZ / RATE_3P8_DHZ * 10;
    localparam logic [1:0] SPEED_FAST = 2'h0;
    localparam logic [1:0] SPEED_15 = 2'h1;
    localparam logic [1:0] SPEED_7P6 = 2'h2;
    localparam logic [1:0] SPEED_3P8 = 2'h3;
    localparam logic [3:0] THR_OFF = 4'h0;
    localparam int LED_SCALE_SH = 4;
endpackage

// ---- verilog/aps_fifo.sv ----
// small valid/ready fifo in the mixed sample path
`timescale 1ns/100ps
module aps_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } aps_fifo_state_s;

    aps_fifo_state_s st_r;
    aps_fifo_state_s st_nxt;
    logic push;
    logic pop;

    assign o_in_ready = (st_r.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_r.cnt != '0);
    assign o_out_data = st_r.mem[st_r.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = i_in_data;
            st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    a_fifo_full_stall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_r.cnt == (AW+1)'(DEPTH)) |-> !o_in_ready ##1 (st_r.cnt <= (AW+1)'(DEPTH)))
        else $error("fifo accepts while full");
endmodule // aps_fifo

// ---- verilog/aps_highpass.sv ----
// first-order dc remover with selectable corner
`timescale 1ns/100ps
module aps_highpass (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_valid,
    input wire logic signed [15:0] i_sample,
    input wire logic i_corner_sel,
    output logic o_valid,
    output logic signed [15:0] o_sample
);
    typedef struct packed {
        logic signed [31:0] dc;
        logic signed [15:0] y;
        logic vld;
    } aps_hp_state_s;

    aps_hp_state_s st_r;
    aps_hp_state_s st_nxt;
    logic signed [16:0] err;
    logic signed [33:0] prod;
    logic [15:0] alpha;

    always_comb begin
        alpha = i_corner_sel ? aps_pkg::HP_ALPHA_510HZ : aps_pkg::HP_ALPHA_80HZ;
        err = {i_sample[15], i_sample} - {st_r.dc[31], st_r.dc[31:16]};
        prod = err * $signed({1'b0, alpha});
        st_nxt = st_r;
        st_nxt.vld = i_valid;
        if (i_valid) begin
            // tracking the mean and subtracting it keeps the adc offset out of the peak
            st_nxt.dc = st_r.dc + 32'(prod);
            st_nxt.y = 16'(err);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_valid = st_r.vld;
    assign o_sample = st_r.y;

    a_hp_latency: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_valid |=> o_valid && (o_sample == 16'($past(err))))
        else $error("high-pass output not one cycle after input");
endmodule // aps_highpass

// ---- verilog/aps_peak_sync.sv ----
// audio peak detector driving the first led brightness
//
// Functional notes
// - sync on: led follows detected audio peak
// - both audio channels mixed into one stream
// - dc removed by high-pass, 80/510 Hz corner
// - sync enable bit 1 on, 0 off
// - sync on: host brightness for led ignored
// - auto gain bit selects auto or manual gain
// - manual gain codes 0 to -46 dB
// - speed field sets led refresh rate
// - threshold code 0 off, else 0.2 mV steps
// - order: buffer, convert, gain, peak, led
// - auto gain matched to input amplitude
// - serial data stable while clock high
// - brightness is linear 8-bit code
`timescale 1ns/100ps
module aps_peak_sync #(
    parameter int unsigned P_REFRESH_FAST_CYC = aps_pkg::REFRESH_FAST_CYC,
    parameter int unsigned P_REFRESH_15_CYC = aps_pkg::REFRESH_15_CYC,
    parameter int unsigned P_REFRESH_7P6_CYC = aps_pkg::REFRESH_7P6_CYC,
    parameter int unsigned P_REFRESH_3P8_CYC = aps_pkg::REFRESH_3P8_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [aps_pkg::SMP_W-1:0] i_audio_input_a,
    input wire logic [aps_pkg::SMP_W-1:0] i_audio_input_b,
    input wire logic i_sample_valid,
    output logic o_sample_ready,
    input wire logic i_sync_enable,
    input wire logic i_auto_gain_enable,
    input wire logic [2:0] i_gain_sel,
    input wire logic [1:0] i_speed_ctrl,
    input wire logic [3:0] i_threshold,
    input wire logic i_highpass_corner_select,
    input wire logic i_first_led_on,
    input wire logic [aps_pkg::LED_W-1:0] i_led_brightness,
    input wire logic i_ctrl_scl,
    input wire logic i_ctrl_sda,
    output logic [aps_pkg::LED_W-1:0] o_first_led_driver,
    output logic [2:0] o_active_gain,
    output logic o_serial_bit,
    output logic o_serial_bit_valid
);
    typedef enum logic [1:0] {
        APS_PH_IDLE = 2'b01,
        APS_PH_BUSY = 2'b10
    } aps_phase_e;

    typedef struct packed {
        aps_phase_e phase;
        logic [31:0] cnt;
        logic [15:0] pk_raw;
        logic [15:0] pk_gain;
        logic [2:0] agc_code;
        logic [7:0] level;
        logic [7:0] led;
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic bit_val;
        logic bit_vld;
    } aps_peak_state_s;

    aps_peak_state_s st_r;
    aps_peak_state_s st_nxt;

    logic [aps_pkg::DAT_W-1:0] mix;
    logic fifo_valid;
    logic fifo_ready;
    logic [aps_pkg::DAT_W-1:0] fifo_data;
    logic hp_valid;
    logic signed [15:0] hp_sample;
    logic [15:0] mag;
    logic [2:0] gain_code;
    logic [24:0] gain_prod;
    logic [15:0] gained;
    logic [31:0] period;
    logic tick;
    logic silent;
    logic [2:0] agc_pick;
    logic [7:0] level_calc;

    // averaging keeps the mixed wave within one channel's range
    assign mix = aps_pkg::DAT_W'(({1'b0, i_audio_input_a} + {1'b0, i_audio_input_b}) >> 1);

    aps_fifo #(
        .WIDTH(aps_pkg::DAT_W),
        .DEPTH(aps_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_sample_valid),
        .o_in_ready(o_sample_ready),
        .i_in_data(mix),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_ready),
        .o_out_data(fifo_data)
    );

    // one sample every second cycle: the gain multiply and peak compare get a full cycle
    assign fifo_ready = (st_r.phase == APS_PH_IDLE);

    aps_highpass u_hp (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(fifo_valid && fifo_ready),
        .i_sample(signed'(fifo_data)),
        .i_corner_sel(i_highpass_corner_select),
        .o_valid(hp_valid),
        .o_sample(hp_sample)
    );

    always_comb begin
        unique case (i_speed_ctrl)
            aps_pkg::SPEED_FAST: period = P_REFRESH_FAST_CYC;
            aps_pkg::SPEED_15: period = P_REFRESH_15_CYC;
            aps_pkg::SPEED_7P6: period = P_REFRESH_7P6_CYC;
            aps_pkg::SPEED_3P8: period = P_REFRESH_3P8_CYC;
        endcase
    end

    assign tick = i_sync_enable && (st_r.cnt >= period - 32'h1);
    assign mag = hp_sample[15] ? 16'(-hp_sample) : 16'(hp_sample);
    assign gain_code = i_auto_gain_enable ? st_r.agc_code : i_gain_sel;
    assign gain_prod = mag * aps_pkg::GAIN_Q8[gain_code];
    assign gained = gain_prod[23:8];
    // threshold steps of about half an adc count sit near 0.2 mV each
    assign silent = (i_threshold != aps_pkg::THR_OFF) && ({st_r.pk_raw, 1'b0} < {13'h0, i_threshold});

    always_comb begin
        agc_pick = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (st_r.pk_raw > aps_pkg::AGC_LIM[i]) begin
                agc_pick = 3'(i + 1);
            end
        end
    end

    always_comb begin
        if (silent) begin
            level_calc = 8'h00;
        end else if (|st_r.pk_gain[15:aps_pkg::LED_W-aps_pkg::LED_SCALE_SH]) begin
            level_calc = 8'hff;
        end else begin
            level_calc = {st_r.pk_gain[3:0], 4'h0};
        end
    end

    always_comb begin
        st_nxt = st_r;
        unique case (st_r.phase)
            APS_PH_IDLE: begin
                if (fifo_valid) begin
                    st_nxt.phase = APS_PH_BUSY;
                end
            end
            APS_PH_BUSY: begin
                st_nxt.phase = APS_PH_IDLE;
            end
        endcase
        if (!i_sync_enable) begin
            // disabled path clears counter, peaks and level for the next enable; the auto gain code is kept
            st_nxt.cnt = 32'h0;
            st_nxt.pk_raw = 16'h0;
            st_nxt.pk_gain = 16'h0;
            st_nxt.level = 8'h00;
        end else if (tick) begin
            st_nxt.cnt = 32'h0;
            st_nxt.level = level_calc;
            if (i_auto_gain_enable) begin
                st_nxt.agc_code = agc_pick;
            end
            st_nxt.pk_raw = hp_valid ? mag : 16'h0;
            st_nxt.pk_gain = hp_valid ? gained : 16'h0;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
            if (hp_valid && mag > st_r.pk_raw) begin
                st_nxt.pk_raw = mag;
            end
            if (hp_valid && gained > st_r.pk_gain) begin
                st_nxt.pk_gain = gained;
            end
        end
        // the led only lights once the host has switched it on
        if (!i_first_led_on) begin
            st_nxt.led = 8'h00;
        end else if (i_sync_enable) begin
            st_nxt.led = st_r.level;
        end else begin
            st_nxt.led = i_led_brightness;
        end
        st_nxt.scl_s1 = i_ctrl_scl;
        st_nxt.scl_s2 = st_r.scl_s1;
        st_nxt.scl_d = st_r.scl_s2;
        st_nxt.sda_s1 = i_ctrl_sda;
        st_nxt.sda_s2 = st_r.sda_s1;
        // data is taken on the clock's rising edge, inside the stable high window
        st_nxt.bit_vld = st_r.scl_s2 && !st_r.scl_d;
        if (st_r.scl_s2 && !st_r.scl_d) begin
            st_nxt.bit_val = st_r.sda_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '{phase: APS_PH_IDLE, cnt: 32'h0, pk_raw: 16'h0, pk_gain: 16'h0, agc_code: 3'h0,
                      level: 8'h00, led: 8'h00, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1,
                      sda_s2: 1'b1, bit_val: 1'b0, bit_vld: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_first_led_driver = st_r.led;
    assign o_active_gain = gain_code;
    assign o_serial_bit = st_r.bit_val;
    assign o_serial_bit_valid = st_r.bit_vld;

    // the halving truncates, so twice the mix may sit one lsb under the sum
    a_mix_average: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (16'(i_audio_input_a) + 16'(i_audio_input_b) - {mix[14:0], 1'b0}) <= 16'h1)
        else $error("channels not averaged");

    a_hp_only_valid: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        hp_valid |-> $past(fifo_valid && fifo_ready))
        else $error("high-pass output without a popped sample");

    a_phase_onehot: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $onehot(st_r.phase))
        else $error("pipeline phase not one-hot");

    a_full_nonempty: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !o_sample_ready |-> fifo_valid)
        else $error("full fifo offers nothing");

    a_sync_off_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_sync_enable |=> (st_r.cnt == 32'h0 && st_r.level == 8'h00 && st_r.pk_raw == 16'h0))
        else $error("sync off left stale state");

    a_no_tick_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_sync_enable |-> !tick)
        else $error("refresh while sync off");

    a_cnt_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        tick |=> (st_r.cnt == 32'h0))
        else $error("refresh counter not restarted");

    // the counter is the only timebase of the refresh, so it must step by one
    a_cnt_step: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_sync_enable && !tick) |=> (st_r.cnt == $past(st_r.cnt) + 32'h1))
        else $error("refresh counter skipped");

    a_refresh_slow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_speed_ctrl == 2'h3) |-> (st_r.cnt >= P_REFRESH_3P8_CYC - 32'h1))
        else $error("slowest refresh fired early");

    a_level_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_sync_enable && !tick) |=> (st_r.level == $past(st_r.level)))
        else $error("level moved inside an interval");

    a_peak_track: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_sync_enable && !tick && hp_valid) |=> (st_r.pk_raw >= $past(mag)))
        else $error("peak lost a larger sample");

    // below saturation the code is the gained peak times sixteen
    a_level_linear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && !silent && st_r.pk_gain < 16'h0010) |=> (st_r.level == 8'($past(st_r.pk_gain) * 16)))
        else $error("level not linear in peak");

    a_silence_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_threshold == 4'h0 && st_r.pk_gain != 16'h0) |=> (st_r.level != 8'h00))
        else $error("peak silenced with threshold off");

    a_agc_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !tick |=> (st_r.agc_code == $past(st_r.agc_code)))
        else $error("auto gain moved between refreshes");

    a_gain_source: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_auto_gain_enable |-> (o_active_gain == st_r.agc_code))
        else $error("auto gain code not in use");

    a_gain_half: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_auto_gain_enable && i_gain_sel == 3'h1 && hp_valid) |-> (gained == (mag >> 1)))
        else $error("manual -6 dB gain wrong");

    // limits 0x200 and 0x400 bracket the -37 dB band
    a_agc_mid: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_auto_gain_enable && st_r.pk_raw > 16'h0200 && st_r.pk_raw <= 16'h0400) |=> (st_r.agc_code == 3'h6))
        else $error("auto gain not -37 dB for mid input");

    a_bit_value: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_serial_bit_valid |-> (o_serial_bit == $past(st_r.sda_s2)))
        else $error("serial bit not the synced data");

    a_led_from_peak: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_sync_enable && i_first_led_on) |=> (o_first_led_driver == $past(st_r.level)))
        else $error("led not taken from audio level while synced");

    a_host_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_sync_enable && i_first_led_on && $past(i_first_led_on) && !tick && !$past(tick) && $past(i_sync_enable))
        |=> $stable(o_first_led_driver))
        else $error("led moved between refreshes while synced");

    a_host_level: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_sync_enable && i_first_led_on) |=> (o_first_led_driver == $past(i_led_brightness)))
        else $error("host brightness not used with sync off");

    a_led_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_first_led_on |=> (o_first_led_driver == 8'h00))
        else $error("led lit while switched off");

    a_unity_gain: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (hp_valid && !tick && i_sync_enable && !i_auto_gain_enable && i_gain_sel == 3'h0)
        |=> (st_r.pk_gain >= $past(mag)))
        else $error("0 dB gain attenuated the sample");

    a_gain_manual: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_auto_gain_enable && i_gain_sel == 3'h7 && hp_valid) |-> (gained == 16'(mag >> 8)))
        else $error("manual -46 dB gain wrong");

    a_agc_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_auto_gain_enable && st_r.pk_raw <= 16'h000d) |=> (st_r.agc_code == 3'h0))
        else $error("auto gain not 0 dB for quiet input");

    a_agc_loud: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_auto_gain_enable && st_r.pk_raw > 16'h0400) |=> (st_r.agc_code == 3'h7))
        else $error("auto gain not -46 dB for loud input");

    a_peak_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && !hp_valid) |=> (st_r.pk_raw == 16'h0 && st_r.pk_gain == 16'h0))
        else $error("peak not restarted after refresh");

    a_thresh_silence: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_threshold != 4'h0 && {st_r.pk_raw, 1'b0} < {13'h0, i_threshold}) |=> (st_r.level == 8'h00))
        else $error("sub-threshold peak lit the led");

    a_led_saturate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_threshold == 4'h0 && st_r.pk_gain >= 16'h0010) |=> (st_r.level == 8'hff))
        else $error("loud peak not full scale");

    a_refresh_fast: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (tick && i_speed_ctrl == 2'h0) |-> (st_r.cnt >= P_REFRESH_FAST_CYC - 32'h1))
        else $error("refresh fired early");

    a_stall_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (fifo_valid && fifo_ready) |=> (hp_valid && !fifo_ready) ##1 fifo_ready)
        else $error("sample pipeline order broken");

    a_bit_on_rise: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_serial_bit_valid |-> ($past(st_r.scl_s2) && !$past(st_r.scl_d)))
        else $error("serial bit taken outside a clock rise");
endmodule // aps_peak_sync

// ---- dv/aps_audio_src.sv ----
// behavioural analogue source: square wave offered on both audio channels
`timescale 1ns/100ps
module aps_audio_src (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [11:0] i_amp,
    input wire logic i_invert_b,
    input wire logic i_ready,
    output logic o_valid,
    output logic [11:0] o_a,
    output logic [11:0] o_b
);
    logic took;
    logic [2:0] ph;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            took <= 1'b0;
        end else begin
            took <= o_valid && i_ready;
        end
    end
    // a pair is held until taken, and a and b always move together
    always @(negedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_valid <= 1'b0;
            ph <= 3'h0;
            o_a <= 12'h000;
            o_b <= 12'h000;
        end else if (took || !o_valid) begin
            o_valid <= 1'b1;
            ph <= ph + 3'h1;
            o_a <= ph[2] ? 12'h800 + i_amp : 12'h800 - i_amp;
            o_b <= (ph[2] ^ i_invert_b) ? 12'h800 + i_amp : 12'h800 - i_amp;
        end
    end
endmodule // aps_audio_src

// ---- dv/tb.sv ----
// self-checking bench for the audio peak led sync path
`timescale 1ns/100ps
module tb;
    localparam int unsigned PER [4] = '{40, 80, 160, 320};
    logic i_clk;
    logic i_arst_n;
    logic [11:0] a;
    logic [11:0] b;
    logic [11:0] amp;
    logic inv_b;
    logic vld;
    logic o_sample_ready;
    logic i_sync_enable;
    logic i_auto_gain_enable;
    logic [2:0] i_gain_sel;
    logic [1:0] i_speed_ctrl;
    logic [3:0] i_threshold;
    logic i_highpass_corner_select;
    logic i_first_led_on;
    logic [7:0] i_led_brightness;
    logic i_ctrl_scl;
    logic i_ctrl_sda;
    logic [7:0] o_first_led_driver;
    logic [2:0] o_active_gain;
    logic o_serial_bit;
    logic o_serial_bit_valid;
    logic [7:0] prev;
    logic [19:0] rnd;
    int errors;
    int samples_checked;
    int k;
    aps_audio_src u_aps_audio_src (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_amp(amp), .i_invert_b(inv_b),
        .i_ready(o_sample_ready), .o_valid(vld), .o_a(a), .o_b(b));
    aps_peak_sync #(.P_REFRESH_FAST_CYC(40), .P_REFRESH_15_CYC(80), .P_REFRESH_7P6_CYC(160),
        .P_REFRESH_3P8_CYC(320)) u_aps_peak_sync (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_audio_input_a(a), .i_audio_input_b(b), .i_sample_valid(vld), .o_sample_ready(o_sample_ready),
        .i_sync_enable(i_sync_enable), .i_auto_gain_enable(i_auto_gain_enable), .i_gain_sel(i_gain_sel),
        .i_speed_ctrl(i_speed_ctrl), .i_threshold(i_threshold),
        .i_highpass_corner_select(i_highpass_corner_select), .i_first_led_on(i_first_led_on),
        .i_led_brightness(i_led_brightness), .i_ctrl_scl(i_ctrl_scl), .i_ctrl_sda(i_ctrl_sda),
        .o_first_led_driver(o_first_led_driver), .o_active_gain(o_active_gain),
        .o_serial_bit(o_serial_bit), .o_serial_bit_valid(o_serial_bit_valid));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function automatic logic [19:0] lfsr_next(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction
    function automatic logic [7:0] host_level(input logic on, input logic [7:0] br);
        return on ? br : 8'h00;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_led(input logic [7:0] exp, input string msg);
        samples_checked++;
        if (o_first_led_driver !== exp) begin
            errors++;
            $display("unexpected led level at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_flag(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected result at %0t: %s", $time, msg);
        end
    endtask
    // the bound covers two sync flops plus the capture edge
    task automatic serial_bit(input logic bv);
        int n;
        i_ctrl_sda = bv;
        cyc(2);
        i_ctrl_scl = 1'b1;
        n = 0;
        while (o_serial_bit_valid !== 1'b1 && n < 8) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (o_serial_bit_valid !== 1'b1) begin
            errors++;
            conclude();
        end
        chk_flag(o_serial_bit === bv, "serial bit");
        cyc(2);
        i_ctrl_scl = 1'b0;
        // data moves only a cycle after the clock has fallen
        cyc(1);
    endtask
    initial begin
        errors = 0;
        samples_checked = 0;
        rnd = 20'h136c0;
        i_arst_n = 1'b0;
        amp = 12'd1000;
        inv_b = 1'b0;
        i_sync_enable = 1'b0;
        i_auto_gain_enable = 1'b0;
        i_gain_sel = 3'h0;
        i_speed_ctrl = 2'h0;
        i_threshold = 4'h0;
        i_highpass_corner_select = 1'b1;
        i_first_led_on = 1'b1;
        i_led_brightness = 8'h00;
        i_ctrl_scl = 1'b0;
        i_ctrl_sda = 1'b0;
        cyc(11);
        chk_flag(o_sample_ready === 1'b1 && o_serial_bit_valid === 1'b0, "reset outputs");
        chk_led(8'h00, "reset level");
        cyc(1);
        i_arst_n = 1'b1;
        // source offers every cycle but drain is one per two cycles, so the fifo must refuse
        k = 0;
        while (o_sample_ready !== 1'b0 && k < 40) begin
            cyc(1);
            k++;
        end
        chk_flag(k < 40, "fifo never full");
        if (k == 40) begin
            conclude();
        end
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr_next(rnd);
            i_led_brightness = rnd[7:0];
            i_first_led_on = rnd[9] | (i == 0);
            cyc(3);
            chk_led(host_level(i_first_led_on, i_led_brightness), "host level");
        end
        i_first_led_on = 1'b1;
        i_sync_enable = 1'b1;
        cyc(3000);
        chk_led(8'hff, "loud audio at 0 dB");
        rnd = lfsr_next(rnd);
        i_led_brightness = rnd[7:0];
        cyc(100);
        chk_led(8'hff, "host brightness not ignored");
        prev = 8'hff;
        for (int g = 0; g < 8; g++) begin
            i_gain_sel = g[2:0];
            cyc(300);
            chk_flag(o_active_gain === g[2:0], "manual gain code");
            chk_flag(o_first_led_driver <= prev, "gain not decreasing");
            prev = o_first_led_driver;
        end
        chk_flag(prev < 8'h80 && prev !== 8'h00, "-46 dB level");
        for (int s = 0; s < 4; s++) begin
            i_speed_ctrl = s[1:0];
            amp = 12'd1000;
            cyc(4 * PER[s]);
            chk_flag(o_first_led_driver !== 8'h00, "level before silence");
            amp = 12'd0;
            k = 0;
            while (o_first_led_driver !== 8'h00 && k < 2 * PER[s] + 40) begin
                cyc(1);
                k++;
            end
            chk_flag(k < 2 * PER[s] + 40, "refresh slower than speed code");
            if (k >= 2 * PER[s] + 40) begin
                conclude();
            end
        end
        i_speed_ctrl = 2'h0;
        i_gain_sel = 3'h0;
        amp = 12'd3;
        cyc(400);
        chk_flag(o_first_led_driver !== 8'h00, "quiet audio without threshold");
        i_threshold = 4'hf;
        cyc(200);
        chk_led(8'h00, "peak under threshold");
        i_threshold = 4'h0;
        amp = 12'd1000;
        inv_b = 1'b1;
        cyc(400);
        chk_led(8'h00, "opposed channels not mixed");
        inv_b = 1'b0;
        i_highpass_corner_select = 1'b0;
        cyc(600);
        chk_led(8'hff, "80 Hz corner passes tone");
        amp = 12'd0;
        cyc(1500);
        chk_led(8'h00, "dc not removed");
        i_auto_gain_enable = 1'b1;
        amp = 12'd1000;
        cyc(400);
        chk_flag(o_active_gain >= 3'h6, "auto gain for loud input");
        amp = 12'd0;
        cyc(1500);
        chk_flag(o_active_gain === 3'h0, "auto gain for silence");
        i_sync_enable = 1'b0;
        cyc(3);
        chk_led(host_level(1'b1, i_led_brightness), "sync off");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            serial_bit(rnd[3]);
        end
        conclude();
    end
endmodule // tb
